// File: include/stfl_pkg.sv
package stfl_pkg;
  // control byte field positions
  localparam int CR_IRQ_EN  = 7;
  localparam int CR_PORT_EN = 6;
  localparam int CR_MASTER  = 4;
  localparam int CR_CPOL    = 3;
  localparam int CR_CPHA    = 2;
  // status byte field positions
  localparam int SR_DONE    = 7;
  localparam int SR_WRITE_COLLISION_FLAG    = 6;
  localparam int SR_MODE_FAULT_FLAG    = 4;
  // synchronised pin lanes
  localparam int PIN_SCK    = 0;
  localparam int PIN_MOSI   = 1;
  localparam int PIN_MISO   = 2;
  localparam int PIN_SS     = 3;
  localparam int PIN_W      = 4;
  // select idles high, the rest low
  localparam logic [3:0] PIN_RST = 4'h8;
  localparam logic [3:0] BYTE_BITS_M1 = 4'h7;
  localparam logic [3:0] BYTE_EDGES_M1 = 4'hf;
  // master capture sees miso through the pin synchroniser, about four cycles late
  localparam int SCK_HALF_CYC_DEF = 8;
  typedef enum logic {ST_IDLE, ST_SHIFT} stfl_state_e;
endpackage

// File: include/stfl_pin_if.sv
`timescale 1ns/1ps
interface stfl_pin_if;
  logic [stfl_pkg::PIN_W-1:0] raw;
  logic [stfl_pkg::PIN_W-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface

// File: core/stfl_pin_sync.sv
`timescale 1ns/1ps
module stfl_pin_sync #(
  parameter logic [stfl_pkg::PIN_W-1:0] RST_VAL = stfl_pkg::PIN_RST
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  stfl_pin_if.sync  pins
);
  for (genvar i = 0; i < stfl_pkg::PIN_W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic cl_r;
    // a change counts only once the second and third stage agree
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        s1_r <= RST_VAL[i];
        s2_r <= RST_VAL[i];
        s3_r <= RST_VAL[i];
        cl_r <= RST_VAL[i];
      end else begin
        s1_r <= pins.raw[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          cl_r <= s3_r;
        end
      end
    end
    assign pins.clean[i] = cl_r;
  end
endmodule

// File: core/stfl_core.sv
// What this block does
// - eight clocks per byte, msb first, full duplex
// - polarity sets serial clock idle level
// - phase set: capture on second edge
// - phase clear: capture on first edge
// - master drives bit one edge before capture
// - unselected slave leaves miso undriven
// - phase clear: select low freezes data
// - phase set: first edge freezes, drives msb
// - phase set: select may stay low
// - write during transfer discarded, collision flagged
// - master collision while own clock shifts
// - collision flag never raises interrupt
// - reads come from cpu-side receive buffer
// - select low as master: fault, drop enables
// - fault clears by status then control write
// - enables unsettable while fault, except clearing write
// - fault never set in slave mode
// - no overrun flag; later bytes lost
// - wait runs normally; halt freezes all but the pin synchroniser
// - done and fault share gated interrupt
// - done blocks writes; status then data clears
`timescale 1ns/1ps
module stfl_core #(
  parameter int unsigned SCK_HALF_CYC = stfl_pkg::SCK_HALF_CYC_DEF
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       dr_wr_i,
  input  wire logic       dr_rd_i,
  input  wire logic [7:0] dr_wdata_i,
  input  wire logic       sr_rd_i,
  input  wire logic       cr_wr_i,
  input  wire logic [7:0] cr_wdata_i,
  input  wire logic       halt_i,
  input  wire logic       global_irq_unmask_i,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  input  wire logic       ss_n_i,
  output logic [7:0]      data_register_o,
  output logic [7:0]      status_register_o,
  output logic [7:0]      control_register_o,
  output logic            irq_o,
  output logic            wake_o
);
  stfl_pin_if pin_if ();
  assign pin_if.raw = {ss_n_i, miso_i, mosi_i, sck_i};
  stfl_pin_sync u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .pins      (pin_if.sync)
  );

  stfl_pkg::stfl_state_e state_r;
  logic       irq_en_r;
  logic       port_en_r;
  logic       master_r;
  logic       cpol_r;
  logic       cpha_r;
  logic       transfer_done_flag_r;
  logic       transfer_done_flag_arm_r;
  logic       write_collision_flag_r;
  logic       write_collision_flag_arm_r;
  logic       mode_fault_flag_r;
  logic       mode_fault_flag_arm_r;
  logic [7:0] shift_r;
  logic [7:0] rx_buf_r;
  logic       out_r;
  logic       phase_r;
  logic [7:0] div_cnt_r;
  logic [3:0] edge_cnt_r;
  logic [3:0] bit_cnt_r;
  logic       frozen_r;
  logic       sck_d_r;

  // halt freezes every register of the block except the pin synchroniser
  wire run = ~halt_i;
  wire sck_s = pin_if.clean[stfl_pkg::PIN_SCK];
  wire mosi_s = pin_if.clean[stfl_pkg::PIN_MOSI];
  wire miso_s = pin_if.clean[stfl_pkg::PIN_MISO];
  wire ss_s = pin_if.clean[stfl_pkg::PIN_SS];

  // master serial clock timing
  wire m_busy = (state_r == stfl_pkg::ST_SHIFT);
  wire tick = m_busy & (div_cnt_r == 8'(SCK_HALF_CYC - 1));
  wire m_lead = tick & ~edge_cnt_r[0];
  wire m_trail = tick & edge_cnt_r[0];
  wire m_done = tick & (edge_cnt_r == stfl_pkg::BYTE_EDGES_M1);

  // slave side: edges of the received clock, judged against idle level
  wire slave_sel = port_en_r & ~master_r & ~ss_s;
  wire s_edge = slave_sel & (sck_s != sck_d_r);
  wire s_lead = s_edge & (sck_d_r == cpol_r);
  wire s_trail = s_edge & (sck_d_r != cpol_r);

  wire lead = master_r ? m_lead : s_lead;
  wire trail = master_r ? m_trail : s_trail;
  wire capture = cpha_r ? trail : lead;
  wire launch = cpha_r ? lead : trail;
  wire din = master_r ? miso_s : mosi_s;
  wire s_done = ~master_r & capture & (bit_cnt_r == stfl_pkg::BYTE_BITS_M1);
  wire done = m_done | s_done;

  // phase clear: data frozen for the whole select; phase set: from first edge
  wire s_busy = slave_sel & (~cpha_r | frozen_r);
  wire busy = m_busy | s_busy;
  wire dr_block = transfer_done_flag_r & ~transfer_done_flag_arm_r;
  wire wr_ok = dr_wr_i & ~busy & ~dr_block;
  wire write_collision_flag_set = dr_wr_i & busy;
  wire start = wr_ok & master_r & port_en_r & ~m_busy;
  wire fault = master_r & port_en_r & ~ss_s;
  wire m_abort = m_busy & ~(master_r & port_en_r);

  wire [7:0] shift_nxt = wr_ok ? dr_wdata_i :
                         capture ? {shift_r[6:0], din} : shift_r;

  // flag clearing sequences; a new event in the clearing cycle wins
  wire dr_acc = dr_rd_i | dr_wr_i;
  wire transfer_done_flag_clr = transfer_done_flag_arm_r & dr_acc;
  wire transfer_done_flag_nxt = done | (transfer_done_flag_r & ~transfer_done_flag_clr);
  wire transfer_done_flag_arm_nxt = ~done & ~transfer_done_flag_clr & transfer_done_flag_r & (transfer_done_flag_arm_r | sr_rd_i);
  wire write_collision_flag_clr = write_collision_flag_arm_r & dr_acc;
  wire write_collision_flag_nxt = write_collision_flag_set | (write_collision_flag_r & ~write_collision_flag_clr);
  wire write_collision_flag_arm_nxt = ~write_collision_flag_set & ~write_collision_flag_clr & write_collision_flag_r & (write_collision_flag_arm_r | sr_rd_i);
  wire mode_fault_flag_clr = mode_fault_flag_arm_r & cr_wr_i;
  wire mode_fault_flag_nxt = fault | (mode_fault_flag_r & ~mode_fault_flag_clr);
  wire mode_fault_flag_arm_nxt = ~fault & ~mode_fault_flag_clr & mode_fault_flag_r & (mode_fault_flag_arm_r | sr_rd_i);

  // enables may only be lowered while a fault stands outside its clearing write
  wire en_lock = mode_fault_flag_r & ~mode_fault_flag_arm_r;
  wire pe_wr = cr_wdata_i[stfl_pkg::CR_PORT_EN] & (~en_lock | port_en_r);
  wire ms_wr = cr_wdata_i[stfl_pkg::CR_MASTER] & (~en_lock | master_r);
  wire port_en_nxt = ~fault & (cr_wr_i ? pe_wr : port_en_r);
  wire master_nxt = ~fault & (cr_wr_i ? ms_wr : master_r);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_en_r <= 1'b0;
      cpol_r <= 1'b0;
      cpha_r <= 1'b0;
      port_en_r <= 1'b0;
      master_r <= 1'b0;
    end else if (run) begin
      if (cr_wr_i) begin
        irq_en_r <= cr_wdata_i[stfl_pkg::CR_IRQ_EN];
        cpol_r <= cr_wdata_i[stfl_pkg::CR_CPOL];
        cpha_r <= cr_wdata_i[stfl_pkg::CR_CPHA];
      end
      port_en_r <= port_en_nxt;
      master_r <= master_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      transfer_done_flag_r <= 1'b0;
      transfer_done_flag_arm_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      write_collision_flag_arm_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
    end else if (run) begin
      transfer_done_flag_r <= transfer_done_flag_nxt;
      transfer_done_flag_arm_r <= transfer_done_flag_arm_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      write_collision_flag_arm_r <= write_collision_flag_arm_nxt;
      mode_fault_flag_r <= mode_fault_flag_nxt;
      mode_fault_flag_arm_r <= mode_fault_flag_arm_nxt;
    end
  end

  // receive buffer only refills once the done flag has been cleared
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_buf_r <= 8'h00;
    end else if (run && done && !transfer_done_flag_r) begin
      rx_buf_r <= shift_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_r <= 8'h00;
      out_r <= 1'b0;
    end else if (run) begin
      shift_r <= shift_nxt;
      if (wr_ok) begin
        out_r <= dr_wdata_i[7];
      end else if (launch) begin
        out_r <= shift_r[7];
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= stfl_pkg::ST_IDLE;
      div_cnt_r <= 8'h00;
      edge_cnt_r <= 4'h0;
      phase_r <= 1'b0;
    end else if (run) begin
      unique case (state_r)
        stfl_pkg::ST_IDLE: begin
          phase_r <= 1'b0;
          div_cnt_r <= 8'h00;
          edge_cnt_r <= 4'h0;
          if (start) begin
            state_r <= stfl_pkg::ST_SHIFT;
          end
        end
        stfl_pkg::ST_SHIFT: begin
          div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
          if (tick) begin
            phase_r <= ~phase_r;
            edge_cnt_r <= edge_cnt_r + 4'h1;
          end
          if (m_done || m_abort) begin
            state_r <= stfl_pkg::ST_IDLE;
            phase_r <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt_r <= 4'h0;
      frozen_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else if (run) begin
      sck_d_r <= sck_s;
      if (start || s_done || (!master_r && ss_s)) begin
        bit_cnt_r <= 4'h0;
      end else if (capture) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (s_done || ss_s || master_r) begin
        frozen_r <= 1'b0;
      end else if (s_lead && cpha_r) begin
        frozen_r <= 1'b1;
      end
    end
  end

  // pins: idle clock level follows polarity even between bytes
  assign sck_o = cpol_r ^ phase_r;
  assign sck_oe_o = port_en_r & master_r;
  assign mosi_o = out_r;
  assign mosi_oe_o = port_en_r & master_r;
  assign miso_o = out_r;
  assign miso_oe_o = slave_sel;

  assign data_register_o = rx_buf_r;
  assign status_register_o = {transfer_done_flag_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
  assign control_register_o = {irq_en_r, port_en_r, 1'b0, master_r,
                               cpol_r, cpha_r, 2'b00};

  // collision flag takes no part in the request; halt suppresses wakeup
  wire irq_req = irq_en_r & (transfer_done_flag_r | mode_fault_flag_r) & run;
  assign wake_o = irq_req;
  assign irq_o = irq_req & global_irq_unmask_i;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  irq_cause_a: assert property (
    irq_o |-> (irq_en_r && global_irq_unmask_i && (transfer_done_flag_r || mode_fault_flag_r)))
    else $error("interrupt without enabled done or fault");

  fault_force_a: assert property (
    (run && master_r && port_en_r && !ss_s) |=> (mode_fault_flag_r && !master_r && !port_en_r))
    else $error("master select low did not force fault");

  slave_nofault_a: assert property (
    (!master_r && !mode_fault_flag_r) |=> !mode_fault_flag_r)
    else $error("fault raised in slave mode");

  collide_flag_a: assert property (
    (run && dr_wr_i && busy && !m_done && !m_abort) |=> (write_collision_flag_r && $stable(state_r)))
    else $error("write during transfer not flagged");

  slave_quiet_a: assert property (
    ss_s |-> !miso_oe_o)
    else $error("deselected slave drives miso");

  idle_level_a: assert property (
    (state_r == stfl_pkg::ST_IDLE) |-> (sck_o == cpol_r))
    else $error("serial clock not at idle level");

  halt_freeze_a: assert property (
    halt_i |=> ($stable(transfer_done_flag_r) && $stable(rx_buf_r) && $stable(shift_r)))
    else $error("registers moved during halt");

  overrun_keep_a: assert property (
    (transfer_done_flag_r && done && !transfer_done_flag_clr) |=> ($stable(rx_buf_r) && transfer_done_flag_r))
    else $error("receive buffer overwritten before clear");

  done_block_a: assert property (
    (run && dr_wr_i && dr_block && !busy) |=> $stable(shift_r) || capture)
    else $error("data write accepted while done flag blocks");
endmodule

// File: testbench/stfl_far_slave.sv
`timescale 1ns/1ps
// far-side slave seen by the block in master mode
module stfl_far_slave (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh_r;
  initial miso_o = 1'b0;
  always @(negedge sel_n_i) begin
    sh_r = tx_i;
    miso_o = tx_i[7];
  end
  // released line flips so a stale bit can never pass for data
  always @(posedge sel_n_i) miso_o = ~miso_o;
  always @(sck_i) begin
    if (!sel_n_i && ((sck_i != mode_i[1]) != mode_i[0])) begin
      rx_o = {rx_o[6:0], mosi_i};
      sh_r = sh_r << 1;
    end else if (!sel_n_i) begin
      miso_o = sh_r[7];
    end
  end
endmodule

// File: testbench/spi_transfer_fault_logic_test.sv
`timescale 1ns/1ps
module spi_transfer_fault_logic_test;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       dr_wr_i = 1'b0;
  logic       dr_rd_i = 1'b0;
  logic       sr_rd_i = 1'b0;
  logic       cr_wr_i = 1'b0;
  logic       halt_i = 1'b0;
  logic       global_irq_unmask_i = 1'b1;
  logic       sck_i = 1'b0;
  logic       mosi_i = 1'b0;
  logic       ss_n_i = 1'b1;
  logic       sel_n = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [7:0] dr_wdata_i = 8'h00;
  logic [7:0] cr_wdata_i = 8'h00;
  logic [7:0] tx, far_tx, rx_far, got;
  logic       sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_i, miso_o, miso_oe_o, irq_o, wake_o;
  logic [7:0] data_register_o, status_register_o, control_register_o;
  int         n_errors = 0;
  int         n_checks = 0;
  int         seed = 70;
  int         cyc = 0;
  int         m;
  always #5 clock_i = ~clock_i;
  stfl_core #(.SCK_HALF_CYC(8)) u_dut (.*);
  stfl_far_slave u_far (.sck_i(sck_o), .mosi_i(mosi_o), .sel_n_i(sel_n), .mode_i(mode),
    .tx_i(far_tx), .miso_o(miso_i), .rx_o(rx_far));
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // k: 0 data write, 1 data read, 2 status access, 3 control write
  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    dr_wdata_i = d;
    cr_wdata_i = d;
    {dr_wr_i, dr_rd_i, sr_rd_i, cr_wr_i} = 4'h8 >> k;
    @(posedge clock_i);
    #1;
    {dr_wr_i, dr_rd_i, sr_rd_i, cr_wr_i} = 4'h0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 400 && status_register_o[7] !== 1'b1; i++) @(posedge clock_i);
    #1;
  endtask
  // outside master, polarity low, phase set, 125 ns link period
  task automatic master_byte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck_i = 1'b1;
      mosi_i = d[i];
      #62.5;
      r[i] = miso_o;
      sck_i = 1'b0;
      #62.5;
    end
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    chk(status_register_o, 8'h00);
    chk(control_register_o, 8'h00);
    chk(8'(sck_oe_o), 8'h00);
    for (m = 0; m < 4; m++) begin
      mode = m[1:0];
      tx = 8'($random(seed));
      far_tx = (m == 0) ? 8'h81 : 8'($random(seed));
      pulse(3, 8'hd0 | {4'h0, mode, 2'h0});
      chk(control_register_o, 8'hd0 | {4'h0, mode, 2'h0});
      chk(8'(sck_o), 8'(mode[1]));
      sel_n = 1'b0;
      pulse(0, tx);
      if (m == 1) begin
        pulse(0, ~tx);
        chk(status_register_o, 8'h40);
        chk(8'(irq_o), 8'h00);
      end
      wait_done();
      chk(data_register_o, far_tx);
      chk(rx_far, tx);
      chk(status_register_o, (m == 1) ? 8'hc0 : 8'h80);
      chk(8'(irq_o), 8'h01);
      sel_n = 1'b1;
      pulse(0, tx);
      repeat (4) @(posedge clock_i);
      #1;
      chk(8'(sck_o), 8'(mode[1]));
      chk(status_register_o, (m == 1) ? 8'hc0 : 8'h80);
      pulse(2, 8'h00);
      pulse(1, 8'h00);
      chk(status_register_o, 8'h00);
    end
    $display("master transfers done");
    pulse(3, 8'hd0);
    ss_n_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
    chk(status_register_o, 8'h10);
    chk(control_register_o, 8'h80);
    chk(8'(irq_o), 8'h01);
    halt_i = 1'b1;
    #1;
    chk(8'(irq_o | wake_o), 8'h00);
    // status access under halt must be lost, so the next write stays blocked
    pulse(2, 8'h00);
    halt_i = 1'b0;
    ss_n_i = 1'b1;
    pulse(3, 8'hd0);
    chk(control_register_o, 8'h80);
    chk(status_register_o, 8'h10);
    pulse(2, 8'h00);
    pulse(3, 8'hd0);
    chk(status_register_o, 8'h00);
    chk(control_register_o, 8'hd0);
    $display("mode fault done");
    pulse(3, 8'h44);
    tx = 8'($random(seed));
    pulse(0, tx);
    ss_n_i = 1'b0;
    #100;
    for (m = 0; m < 2; m++) begin
      far_tx = 8'($random(seed));
      master_byte(far_tx, got);
      wait_done();
      chk(8'(miso_oe_o), 8'h01);
      chk(got, tx);
      chk(data_register_o, far_tx);
      chk(status_register_o, 8'h80);
      tx = 8'($random(seed));
      pulse(2, 8'h00);
      pulse(0, tx);
    end
    // two bytes without clearing: the second one is lost
    far_tx = 8'($random(seed));
    master_byte(far_tx, got);
    master_byte(~far_tx, got);
    wait_done();
    repeat (8) @(posedge clock_i);
    #1;
    chk(data_register_o, far_tx);
    pulse(2, 8'h00);
    pulse(1, 8'h00);
    ss_n_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    // slave, phase clear: select low freezes the data register
    pulse(3, 8'h40);
    tx = 8'($random(seed));
    pulse(0, tx);
    ss_n_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
    pulse(0, ~tx);
    chk(status_register_o, 8'h40);
    far_tx = 8'($random(seed));
    master_byte(far_tx, got);
    wait_done();
    chk(got, tx);
    chk(data_register_o, far_tx);
    chk(status_register_o, 8'hc0);
    ss_n_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    pulse(2, 8'h00);
    pulse(1, 8'h00);
    chk(status_register_o, 8'h00);
    ss_n_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1;
    chk(8'(miso_oe_o), 8'h00);
    $display("slave transfers done");
    complete_run();
  end
endmodule
